// File: bench/ack_button_model.sv
/*
  Operator acknowledge pushbutton model.
  Assumes the bench raises go for one cycle at a falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ack_button_model (
  input  wire logic sys_clk,
  input  wire logic go,
  output var  logic button
);
  // ****************************************
  // press off the clock grid, held 8 cycles
  // ****************************************
  initial begin
    button = 1'b0;
    forever begin
      @(posedge sys_clk iff go);
      #13 button = 1'b1;
      repeat (8) @(posedge sys_clk);
      #7 button = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: bench/event_history_logger_asserts.sv
/*
  Concurrent checks on the event logger ports.
  Assumes event_logger_params.svh on the include path; bound below.
*/
`include "event_logger_params.svh"
`timescale 1ns/1ps
`default_nettype none
module event_history_logger_asserts #(
  parameter int DEPTH = `EVL_HIST_DEPTH
) (
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  input wire logic                   ack_button,
  input wire logic                   s1_connected,
  input wire logic                   s2_connected,
  input wire logic [`EVL_CHECKS-1:0] s1_checks_ok,
  input wire logic [`EVL_CHECKS-1:0] s2_checks_ok,
  input wire logic                   gen_pri_demand,
  input wire logic                   gen_sec_demand,
  input wire logic                   gen_to_gen_mode,
  input wire logic                   s1_conn_lamp,
  input wire logic                   s1_conn_relay,
  input wire logic                   s2_conn_lamp,
  input wire logic                   s1_avail_lamp,
  input wire logic                   s2_avail_lamp,
  input wire logic                   gen_pri_start,
  input wire logic                   gen_sec_start,
  input wire logic                   disp_valid,
  input wire logic [`EVL_ID_W-1:0]   disp_id,
  input wire logic                   disp_active,
  input wire logic [$clog2(DEPTH+1)-1:0] hist_count
);
  // ****************************************
  // output relations
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_s1c; $past(resetn, 2) |-> s1_conn_lamp == $past(s1_connected) && s1_conn_relay == s1_conn_lamp; endproperty
  a_s1c: assert property (p_s1c) else $error("s1 connected output wrong");
  property p_s2c; $past(resetn, 2) |-> s2_conn_lamp == $past(s2_connected); endproperty
  a_s2c: assert property (p_s2c) else $error("s2 connected output wrong");
  property p_s1a; $past(resetn, 2) |-> s1_avail_lamp == &$past(s1_checks_ok); endproperty
  a_s1a: assert property (p_s1a) else $error("s1 available output wrong");
  property p_s2a; $past(resetn, 2) |-> s2_avail_lamp == &$past(s2_checks_ok); endproperty
  a_s2a: assert property (p_s2a) else $error("s2 available output wrong");
  property p_gpri; $past(resetn, 2) |-> gen_pri_start == $past(gen_pri_demand); endproperty
  a_gpri: assert property (p_gpri) else $error("primary start wrong");
  property p_gsec; $past(resetn, 2) |-> gen_sec_start == ($past(gen_sec_demand) && $past(gen_to_gen_mode)); endproperty
  a_gsec: assert property (p_gsec) else $error("secondary start wrong");
  property p_dsp; $past(resetn, 2) && $rose(s1_connected) |=> disp_valid && disp_active && disp_id == `EVL_ID_S1_CONN; endproperty
  a_dsp: assert property (p_dsp) else $error("newest event not shown");
  property p_hist; $past(resetn) |-> hist_count <= DEPTH && hist_count >= $past(hist_count) && hist_count <= $past(hist_count) + 1; endproperty
  a_hist: assert property (p_hist) else $error("history count wrong");
  property p_ack; $fell(disp_valid) |-> $past(ack_button, 3) || $past(ack_button, 4) || $past(ack_button, 5); endproperty
  a_ack: assert property (p_ack) else $error("display cleared without press");
  c_ack: cover property ($fell(disp_valid));
  c_full: cover property (hist_count == DEPTH);
  c_gsec: cover property ($rose(gen_sec_start));
endmodule
bind event_history_logger event_history_logger_asserts #(.DEPTH(DEPTH)) u_chk (.*);
`default_nettype wire

// File: bench/event_history_logger_test.sv
/*
  Self-checking bench for the event history logger against a queue model.
  Assumes the logger, its bound checker and the pushbutton model.
*/
`include "event_logger_params.svh"
`timescale 1ns/1ps
`default_nettype none
module event_history_logger_test;
  localparam int D = 4;
  logic        sys_clk = 1'b0, resetn = 1'b0, go = 1'b0, ack_button;
  logic        s1_connected = 1'b0, s2_connected = 1'b0, gen_pri_demand = 1'b0;
  logic        gen_sec_demand = 1'b0, gen_to_gen_mode = 1'b1;
  logic [4:0]  s1_checks_ok = 5'h00, s2_checks_ok = 5'h00;
  logic [31:0] time_stamp = 32'h0, seed = 32'h5B06, disp_stamp, hist_rd_stamp;
  logic [31:0] qs[$], dst = 32'h0;
  logic [1:0]  hist_rd_index = 2'h0;
  logic [2:0]  disp_id, hist_rd_id, hist_count;
  logic        s1_conn_lamp, s1_conn_relay, s2_conn_lamp, s2_conn_relay, s1_avail_lamp;
  logic        s1_avail_relay, s2_avail_lamp, s2_avail_relay, gen_pri_start, gen_sec_start;
  logic        disp_valid, disp_active, hist_rd_valid, hist_rd_active, hist_rd_acked, dv = 1'b0;
  logic [5:0]  st = 6'h00, e;
  int          q[$], n_mismatch = 0, num_checks = 0, npush = 0, cyc = 0, did, dact;
  event_history_logger #(.DEPTH(D)) uut (.*);
  ack_button_model pb (.sys_clk(sys_clk), .go(go), .button(ack_button));
  // ****************************************
  // clock, stamp, timeout and output monitor
  // ****************************************
  initial forever #20 sys_clk = ~sys_clk;
  always @(negedge sys_clk) time_stamp <= time_stamp + 32'h1;
  always @(posedge sys_clk) begin
    e = {s1_connected, s2_connected, &s1_checks_ok, &s2_checks_ok, gen_pri_demand,
         gen_sec_demand & gen_to_gen_mode};
    #1;
    if (++cyc > 3000) begin
      n_mismatch++;
      finish_test();
    end
    if (resetn) begin
      chk({s1_conn_lamp, s2_conn_lamp, s1_avail_lamp, s2_avail_lamp, gen_pri_start, gen_sec_start}, e);
      chk({s1_conn_relay, s2_conn_relay, s1_avail_relay, s2_avail_relay}, e[5:2]);
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // model record: id, active, acked
  task automatic push(input int r, input logic [31:0] s);
    q.push_back(r);
    qs.push_back(s);
    if (q.size() > D) begin
      void'(q.pop_front());
      void'(qs.pop_front());
    end
    npush++;
    hist_rd_index = 2'((npush - 1) % D);
  endtask
  task automatic look();
    chk(hist_count, q.size());
    if (q.size() > 0) begin
      chk({hist_rd_valid, hist_rd_id, hist_rd_active, hist_rd_acked}, 32'h20 | q[$]);
      chk(hist_rd_stamp, qs[$]);
    end
  endtask
  // toggle one event and check display and newest history slot
  task automatic ev(input int k, input int a = 0);
    @(negedge sys_clk);
    st[k] = ~st[k];
    s1_connected = st[0];
    s2_connected = st[1];
    s1_checks_ok = st[2] ? 5'h1F : 5'h1F & ~(5'h01 << (xs() % 5));
    s2_checks_ok = st[3] ? 5'h1F : 5'h1F & ~(5'h01 << (xs() % 5));
    gen_pri_demand = st[4];
    gen_sec_demand = st[5];
    if (a != 0) foreach (q[i]) q[i] |= 1;
    if (dv) push(did * 4 + dact * 2 + a, dst);
    dv = 1'b1;
    did = k;
    dact = int'(st[k]);
    @(posedge sys_clk);
    dst = time_stamp;
    repeat (3) @(negedge sys_clk);
    chk({disp_valid, disp_id, disp_active}, {dv, did[2:0], dact[0]});
    chk(disp_stamp, dst);
    look();
  endtask
  task automatic ack();
    @(negedge sys_clk);
    go = 1'b1;
    @(negedge sys_clk);
    go = 1'b0;
    repeat (14) @(negedge sys_clk);
    foreach (q[i]) q[i] |= 1;
    if (dv) push(did * 4 + dact * 2 + 1, dst);
    dv = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(disp_valid, 0);
    look();
    // read every stored slot back, all now acknowledged
    foreach (q[i]) begin
      hist_rd_index = 2'((npush - q.size() + i) % D);
      repeat (2) @(negedge sys_clk);
      chk({hist_rd_valid, hist_rd_id, hist_rd_active, hist_rd_acked}, 32'h20 | q[i]);
      chk(hist_rd_stamp, qs[i]);
    end
  endtask
  // press whose pulse lands in the same cycle as an event change
  task automatic ack_ev(input int k);
    @(negedge sys_clk);
    go = 1'b1;
    @(negedge sys_clk);
    go = 1'b0;
    repeat (3) @(negedge sys_clk);
    ev(k, 1);
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int k = 0; k < 6; k++) ev(k);
    ack();
    ev(5);
    gen_to_gen_mode = 1'b0;
    gen_sec_demand = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk({disp_id, disp_active}, {did[2:0], dact[0]});
    look();
    gen_sec_demand = 1'b0;
    gen_to_gen_mode = 1'b1;
    ack_ev(2);
    for (int i = 0; i < 40; i++) begin
      ev(int'(xs() % 6));
      if (i % 9 == 8) ack();
    end
    finish_test();
  end
endmodule
`default_nettype wire

// File: src/ack_press_sync.sv
/*
  Synchroniser and edge detector for the operator acknowledge pushbutton.
  Assumes an asynchronous, active-high button level and one system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ack_press_sync (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic button,
  output var  logic press
);
  typedef struct packed {
    logic [2:0] sync;
    logic       level;
    logic       press;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // three stages, change taken once stages two and three agree
  always_comb begin
    next_state       = state;
    next_state.sync  = {state.sync[1:0], button};
    next_state.press = 1'b0;
    if (state.sync[2] == state.sync[1] && state.sync[2] != state.level) begin
      next_state.level = state.sync[2];
      next_state.press = state.sync[2]; // RULE_14
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign press = state.press;
endmodule
`default_nettype wire

// File: src/event_history_logger.sv
/*
  Event annunciation and history logging for a transfer switch controller:
  status indicators, relay and start outputs, displayed event, and a
  circular history of past events with acknowledge handling.
  Assumes synchronous status inputs from the controller logic, an
  asynchronous acknowledge button and a free-running timestamp from the
  controller clock.
  Simultaneous status changes are logged one per cycle, lowest id first.
  History is read by physical slot; the record appears one cycle after the
  index, and an index past the store depth reads as an empty record.
  An acknowledge press marks every stored entry acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
`include "event_logger_params.svh"
module event_history_logger #(
  parameter int DEPTH = `EVL_HIST_DEPTH
) (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic                       ack_button,
  input  wire logic [`EVL_TS_W-1:0]       time_stamp,
  input  wire logic                       s1_connected,
  input  wire logic                       s2_connected,
  input  wire logic [`EVL_CHECKS-1:0]     s1_checks_ok,
  input  wire logic [`EVL_CHECKS-1:0]     s2_checks_ok,
  input  wire logic                       gen_pri_demand,
  input  wire logic                       gen_sec_demand,
  input  wire logic                       gen_to_gen_mode,
  output logic                            s1_conn_lamp,
  output logic                            s1_conn_relay,
  output logic                            s2_conn_lamp,
  output logic                            s2_conn_relay,
  output logic                            s1_avail_lamp,
  output logic                            s1_avail_relay,
  output logic                            s2_avail_lamp,
  output logic                            s2_avail_relay,
  output logic                            gen_pri_start,
  output logic                            gen_sec_start,
  output logic                            disp_valid,
  output logic [`EVL_ID_W-1:0]            disp_id,
  output logic [`EVL_TS_W-1:0]            disp_stamp,
  output logic                            disp_active,
  output logic [$clog2(DEPTH+1)-1:0]      hist_count,
  input  wire logic [$clog2(DEPTH)-1:0]   hist_rd_index,
  output logic                            hist_rd_valid,
  output logic [`EVL_ID_W-1:0]            hist_rd_id,
  output logic [`EVL_TS_W-1:0]            hist_rd_stamp,
  output logic                            hist_rd_active,
  output logic                            hist_rd_acked
);
  // pointer, counter and event vector widths
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int NE = `EVL_NUM_EVENTS;

  // ************************************************************
  // state
  // ************************************************************
  // block state apart from the history array, registered in one always_ff
  typedef struct packed {
    logic [NE-1:0]                  ev;
    event_logger_pkg::event_rec_t   disp;
    logic [PW-1:0]                  wptr;
    logic [CW-1:0]                  count;
    event_logger_pkg::event_rec_t   rd;
  } log_state_t;

  // state and its next value; the history array sits beside it
  log_state_t state;
  log_state_t next_state;
  event_logger_pkg::event_rec_t hist [DEPTH];

  // helpers of the next-state logic
  logic          ack_pulse;
  logic [NE-1:0] ev_now;
  logic          push;
  logic          new_ev;
  logic [`EVL_ID_W-1:0] new_id;
  logic          new_act;
  event_logger_pkg::event_rec_t push_rec;

  // acknowledge button: three-flop sync and one-cycle press pulse
  ack_press_sync u_ack (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .button  (ack_button),
    .press   (ack_pulse)
  );

  // ************************************************************
  // event conditions
  // ************************************************************
  assign ev_now[`EVL_ID_S1_CONN]  = s1_connected;                    // RULE_08
  assign ev_now[`EVL_ID_S2_CONN]  = s2_connected;                    // RULE_09
  assign ev_now[`EVL_ID_S1_AVAIL] = &s1_checks_ok;                   // RULE_10
  assign ev_now[`EVL_ID_S2_AVAIL] = &s2_checks_ok;                   // RULE_11
  assign ev_now[`EVL_ID_GEN_PRI]  = gen_pri_demand;                  // RULE_12
  assign ev_now[`EVL_ID_GEN_SEC]  = gen_sec_demand & gen_to_gen_mode; // RULE_13

  // lowest-numbered changing event this cycle; others caught next cycles
  function automatic logic [`EVL_ID_W-1:0] first_change(input logic [NE-1:0] d);
    logic [`EVL_ID_W-1:0] r;
    r = '0;
    for (int i = NE - 1; i >= 0; i--) begin
      if (d[i]) begin
        r = `EVL_ID_W'(i);
      end
    end
    return r;
  endfunction

  // ************************************************************
  // display and history control
  // ************************************************************
  always_comb begin
    // defaults: hold state, push the shown record as it stands
    next_state = state;
    push       = 1'b0;
    push_rec   = state.disp;
    // changed events against the stored vector
    new_ev     = |(ev_now ^ state.ev);
    new_id     = first_change(ev_now ^ state.ev);
    new_act    = ev_now[new_id];
    if (new_ev) begin
      // take over one changed bit into the event vector
      next_state.ev[new_id] = new_act;
      // new event replaces the shown one, old one goes to history
      if (state.disp.valid) begin
        push = 1'b1;                                                 // RULE_05
      end
      next_state.disp.valid  = 1'b1;                                 // RULE_04
      next_state.disp.id     = new_id;                               // RULE_02
      next_state.disp.stamp  = time_stamp;                           // RULE_02
      next_state.disp.active = new_act;                              // RULE_01
      next_state.disp.acked  = 1'b0;
      // press in the same cycle: pushed record leaves acknowledged
      if (ack_pulse && state.disp.valid) begin
        push_rec.acked = 1'b1;
      end
    end else if (ack_pulse && state.disp.valid) begin
      // acknowledge moves the shown event to history
      push                  = 1'b1;                                  // RULE_03
      push_rec.acked        = 1'b1;                                  // RULE_03
      next_state.disp.valid = 1'b0;                                  // RULE_04
    end
    if (push) begin
      // circular store, oldest slot overwritten when full
      next_state.wptr = (state.wptr == PW'(DEPTH - 1)) ? '0 : state.wptr + 1'b1; // RULE_07
      // count saturates at the store depth
      if (state.count != CW'(DEPTH)) begin
        next_state.count = state.count + 1'b1;                       // RULE_07
      end
    end
    // registered history read, empty record past the store depth
    if (int'(hist_rd_index) < DEPTH) begin
      next_state.rd = hist[hist_rd_index];
    end else begin
      next_state.rd = '0;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // history store
  // ************************************************************
  // history array, acknowledge marks all stored entries
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      // a write wins over the acknowledge on its own slot
      if (!resetn) begin
        hist[i] <= '0;
      end else if (push && state.wptr == PW'(i)) begin
        hist[i] <= push_rec;                                         // RULE_07
      end else if (ack_pulse) begin
        hist[i].acked <= hist[i].valid;                              // RULE_06
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // all outputs come straight from state flip-flops
  // source connected indicators and relays
  assign s1_conn_lamp   = state.ev[`EVL_ID_S1_CONN];
  assign s1_conn_relay  = state.ev[`EVL_ID_S1_CONN];
  assign s2_conn_lamp   = state.ev[`EVL_ID_S2_CONN];
  assign s2_conn_relay  = state.ev[`EVL_ID_S2_CONN];

  // source available indicators and relays
  assign s1_avail_lamp  = state.ev[`EVL_ID_S1_AVAIL];
  assign s1_avail_relay = state.ev[`EVL_ID_S1_AVAIL];
  assign s2_avail_lamp  = state.ev[`EVL_ID_S2_AVAIL];
  assign s2_avail_relay = state.ev[`EVL_ID_S2_AVAIL];

  // generator start outputs
  assign gen_pri_start  = state.ev[`EVL_ID_GEN_PRI];
  assign gen_sec_start  = state.ev[`EVL_ID_GEN_SEC];

  // displayed event
  assign disp_valid     = state.disp.valid;
  assign disp_id        = state.disp.id;
  assign disp_stamp     = state.disp.stamp;
  assign disp_active    = state.disp.active;

  // history count and read-back
  assign hist_count     = state.count;
  assign hist_rd_valid  = state.rd.valid;
  assign hist_rd_id     = state.rd.id;
  assign hist_rd_stamp  = state.rd.stamp;
  assign hist_rd_active = state.rd.active;
  assign hist_rd_acked  = state.rd.acked;
endmodule
`default_nettype wire

// File: src/event_logger_params.svh
/*
  Constants for the event history logger: event codes, widths and the depth
  of the history store.
  Assumes nothing of its surroundings; included by bare name.
*/
// Functional notes
// RULE_01: one record format for all events
// RULE_02: record holds id, timestamp, active marker
// RULE_03: reset press acknowledges, moves events to history
// RULE_04: display holds latest until acked or replaced
// RULE_05: newer event pushes unacked one to history
// RULE_06: reset press acknowledges history entries
// RULE_07: history holds 50, oldest overwritten
// RULE_08: source one connected event, lamp, relay
// RULE_09: source two connected event, lamp, relay
// RULE_10: source one available when all checks good
// RULE_11: source two available when all checks good
// RULE_12: primary generator start event and output
// RULE_13: secondary start only in gen-to-gen mode
// RULE_14: one press gives one acknowledge pulse
`ifndef EVENT_LOGGER_PARAMS_SVH
`define EVENT_LOGGER_PARAMS_SVH
`define EVL_HIST_DEPTH   50
`define EVL_ID_W         3
`define EVL_TS_W         32
`define EVL_NUM_EVENTS   6
`define EVL_ID_S1_CONN   3'h0
`define EVL_ID_S2_CONN   3'h1
`define EVL_ID_S1_AVAIL  3'h2
`define EVL_ID_S2_AVAIL  3'h3
`define EVL_ID_GEN_PRI   3'h4
`define EVL_ID_GEN_SEC   3'h5
`define EVL_CHECKS       5
`endif

// File: src/event_logger_pkg.sv
/*
  Types for the event history logger.
  Assumes event_logger_params.svh is on the include path.
*/
`include "event_logger_params.svh"
package event_logger_pkg;
  // common record for fault and non-fault events
  typedef struct packed {
    logic                   valid;
    logic [`EVL_ID_W-1:0]   id;
    logic [`EVL_TS_W-1:0]   stamp;
    logic                   active;
    logic                   acked;
  } event_rec_t;
endpackage
